// ---- cie_periph.sv ----
// behavioural peripheral side for the interrupt enable and response unit
// assumes the bench pulses nmi_req/int_req on pclk and watches int_accept
`timescale 1ns/1ps
`default_nettype none

module cie_periph (
    input wire logic pclk,              // cpu clock
    input wire logic presetn,           // async reset, active low
    input wire logic nmi_req,           // bench: hold nmi pin low this cycle
    input wire logic int_req,           // bench: start a maskable request
    input wire logic [7:0] vec_in,      // vector this peripheral hands over
    input wire logic int_accept,        // acknowledge from the unit
    output logic nmi_n,                 // non-maskable request pin
    output logic int_n,                 // maskable request pin
    output logic [7:0] periph_vector    // byte read in acknowledge
);
    logic int_pend;
    logic [7:0] idle_pat;

    // ------------------------------------------------------------
    // request line held until acknowledged
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_pend <= 1'b0;
        else if (int_req)
            int_pend <= 1'b1;
        else if (int_accept)
            int_pend <= 1'b0;
    end

    // released data bus shows a moving pattern, never a stale vector
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_pat <= 8'h5A;
        else
            idle_pat <= ~idle_pat;
    end

    assign nmi_n = ~nmi_req;
    // wired-or line with pull-up: high once released
    assign int_n = ~int_pend;
    assign periph_vector = int_pend ? {vec_in[7:1], 1'b0} : idle_pat;
endmodule : cie_periph

`default_nettype wire

// ---- cie_pkg.sv ----
// constants shared by the interrupt enable and response unit
// assumes a single pclk domain and an apb register port
package cie_pkg;

    // ------------------------------------------------------------
    // fixed restart targets and acknowledge wait counts
    // ------------------------------------------------------------
    localparam logic [15:0] NMI_VECTOR = 16'h0066;
    localparam logic [15:0] MODE1_VECTOR = 16'h0038;
    localparam logic [1:0] INT_WAIT_STATES = 2'h2;
    localparam logic [1:0] NO_WAIT_STATES = 2'h0;

    // ------------------------------------------------------------
    // maskable response modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CIE_MODE0 = 2'h0,
        CIE_MODE1 = 2'h1,
        CIE_MODE2 = 2'h2
    } cie_mode_e;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam int CTRL_MODE_LSB = 0;
    localparam int STAT_LIVE_BIT = 0;
    localparam int STAT_SAVED_BIT = 1;
    localparam int STAT_NMI_PEND_BIT = 2;
    localparam int STAT_EI_HOLD_BIT = 3;
    localparam int STAT_MODE_LSB = 4;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : cie_pkg

// ---- cie_unit.sv ----
// interrupt enable flip-flops and interrupt acceptance for an 8-bit cpu core
// assumes the core gives decoded instruction pulses at least one cycle before
// the instruction boundary pulse, and software reaches ctrl/status over apb
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module cie_unit (
    input wire logic pclk,                  // cpu clock, 100 MHz
    input wire logic presetn,               // async reset, active low
    input wire logic psel,                  // apb select
    input wire logic penable,               // apb access phase
    input wire logic pwrite,                // apb direction
    input wire logic [11:0] paddr,          // apb byte address
    input wire logic [31:0] pwdata,         // apb write data
    output logic [31:0] prdata,             // apb read data
    output logic pready,                    // apb ready
    output logic pslverr,                   // apb error, unmapped address
    input wire logic nmi_n,                 // non-maskable request pin
    input wire logic int_n,                 // maskable request pin, wired-or
    input wire logic instr_boundary,        // end of instruction pulse
    input wire logic exec_irq_enable,       // enable instruction executed
    input wire logic exec_irq_mask,         // mask instruction executed
    input wire logic exec_load_acc_vb,      // load acc from vector base
    input wire logic exec_load_acc_rf,      // load acc from refresh
    input wire logic exec_return_from_nonmaskable,             // return from non-maskable
    input wire logic exec_set_mode,         // mode select instruction
    input wire logic [1:0] exec_mode,       // mode carried by it
    input wire logic [7:0] vector_base,     // vector base register
    input wire logic [7:0] periph_vector,   // byte read in acknowledge
    output logic irq_enable_live,           // live enable flip-flop
    output logic irq_enable_saved,          // saved enable flip-flop
    output logic parity_load,               // pulse: write parity flag
    output logic parity_value,              // value for parity flag
    output logic nmi_accept,                // pulse: nmi accepted
    output logic int_accept,                // pulse: maskable accepted
    output logic discard_fetch,             // pulse: drop next fetch
    output logic push_pc,                   // pulse: push program counter
    output logic jump_valid,                // pulse: jump_addr valid
    output logic [15:0] jump_addr,          // restart target
    output logic table_valid,               // pulse: mode 2 pointer valid
    output logic [15:0] table_ptr,          // mode 2 table pointer
    output logic bus_instr,                 // pulse: run instruction from bus
    output logic [1:0] wait_states,         // extra acknowledge waits
    output logic [1:0] int_mode             // current maskable mode
);

    // ------------------------------------------------------------
    // pin synchronisers and nmi edge latch
    // ------------------------------------------------------------
    logic nmi_meta, nmi_sync, nmi_prev;
    logic int_meta, int_sync;
    logic nmi_pending;
    logic ei_hold;
    logic take_nmi, take_int, nmi_edge;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_meta <= 1'b1;
            nmi_sync <= 1'b1;
            nmi_prev <= 1'b1;
            int_meta <= 1'b1;
            int_sync <= 1'b1;
        end
        else
        begin
            nmi_meta <= nmi_n;
            nmi_sync <= nmi_meta;
            nmi_prev <= nmi_sync;
            int_meta <= int_n;
            int_sync <= int_meta;
        end
    end

    assign nmi_edge = nmi_prev & ~nmi_sync;
    // nmi outranks int; enable state never gates nmi
    assign take_nmi = instr_boundary & nmi_pending;
    assign take_int = instr_boundary & ~take_nmi & ~int_sync & irq_enable_live
                      & ~ei_hold & ~exec_irq_enable;

    // short pulses survive until the next boundary; a new edge beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nmi_pending <= 1'b0;
        else if (nmi_edge)
            nmi_pending <= 1'b1;
        else if (take_nmi)
            nmi_pending <= 1'b0;
    end

    // one-instruction hold-off after the enable instruction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ei_hold <= 1'b0;
        else if (exec_irq_enable)
            ei_hold <= 1'b1;
        else if (instr_boundary)
            ei_hold <= 1'b0;
    end

    // ------------------------------------------------------------
    // enable flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_enable_live <= 1'b0;
            irq_enable_saved <= 1'b0;
        end
        else if (take_nmi)
            irq_enable_live <= 1'b0;
        else if (take_int)
        begin
            irq_enable_live <= 1'b0;
            irq_enable_saved <= 1'b0;
        end
        else if (exec_irq_enable)
        begin
            irq_enable_live <= 1'b1;
            irq_enable_saved <= 1'b1;
        end
        else if (exec_irq_mask)
        begin
            irq_enable_live <= 1'b0;
            irq_enable_saved <= 1'b0;
        end
        else if (exec_return_from_nonmaskable)
            irq_enable_live <= irq_enable_saved;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            parity_load <= 1'b0;
            parity_value <= 1'b0;
        end
        else
        begin
            parity_load <= exec_load_acc_vb | exec_load_acc_rf;
            if (exec_load_acc_vb | exec_load_acc_rf)
                parity_value <= irq_enable_saved;
        end
    end

    // ------------------------------------------------------------
    // response mode, instruction beats software on a tie
    // ------------------------------------------------------------
    logic apb_write;
    assign apb_write = psel & penable & pready & pwrite;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_mode <= cie_pkg::MODE_RESET;
        else if (exec_set_mode)
            int_mode <= exec_mode;
        else if (apb_write && paddr == cie_pkg::ADDR_CTRL)
            int_mode <= pwdata[cie_pkg::CTRL_MODE_LSB +: 2];
    end

    // ------------------------------------------------------------
    // response outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_accept <= 1'b0;
            int_accept <= 1'b0;
            discard_fetch <= 1'b0;
            push_pc <= 1'b0;
            jump_valid <= 1'b0;
            jump_addr <= cie_pkg::NMI_VECTOR;
            table_valid <= 1'b0;
            table_ptr <= 16'h0000;
            bus_instr <= 1'b0;
            wait_states <= cie_pkg::NO_WAIT_STATES;
        end
        else
        begin
            nmi_accept <= take_nmi;
            int_accept <= take_int;
            discard_fetch <= take_nmi;
            push_pc <= take_nmi | (take_int && int_mode != cie_pkg::CIE_MODE0);
            jump_valid <= 1'b0;
            table_valid <= 1'b0;
            bus_instr <= 1'b0;
            if (take_nmi)
            begin
                jump_valid <= 1'b1;
                jump_addr <= cie_pkg::NMI_VECTOR;
                wait_states <= cie_pkg::NO_WAIT_STATES;
            end
            else if (take_int)
            begin
                wait_states <= cie_pkg::INT_WAIT_STATES;
                if (int_mode == cie_pkg::CIE_MODE1)
                begin
                    jump_valid <= 1'b1;
                    jump_addr <= cie_pkg::MODE1_VECTOR;
                end
                else if (int_mode == cie_pkg::CIE_MODE2)
                begin
                    table_valid <= 1'b1;
                    table_ptr <= {vector_base, periph_vector[7:1], 1'b0};
                end
                else
                    bus_instr <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // apb slave, one wait-free access phase
    // ------------------------------------------------------------
    logic addr_ok;
    assign addr_ok = (paddr == cie_pkg::ADDR_CTRL) || (paddr == cie_pkg::ADDR_STATUS);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= cie_pkg::RDATA_ZERO;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata <= cie_pkg::RDATA_ZERO;
            if (psel && !penable && !pwrite)
            begin
                if (paddr == cie_pkg::ADDR_CTRL)
                    prdata[cie_pkg::CTRL_MODE_LSB +: 2] <= int_mode;
                else if (paddr == cie_pkg::ADDR_STATUS)
                begin
                    prdata[cie_pkg::STAT_LIVE_BIT] <= irq_enable_live;
                    prdata[cie_pkg::STAT_SAVED_BIT] <= irq_enable_saved;
                    prdata[cie_pkg::STAT_NMI_PEND_BIT] <= nmi_pending;
                    prdata[cie_pkg::STAT_EI_HOLD_BIT] <= ei_hold;
                    prdata[cie_pkg::STAT_MODE_LSB +: 2] <= int_mode;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_nmi_take;
        instr_boundary && nmi_pending;
    endsequence
    sequence s_nmi_response;
        nmi_accept && discard_fetch && push_pc && jump_valid
        && jump_addr == cie_pkg::NMI_VECTOR;
    endsequence
    property p_nmi_always;
        s_nmi_take |=> s_nmi_response;
    endproperty
    a_nmi_always: assert property (p_nmi_always) else $error("nmi not taken");
    property p_int_gated;
        int_accept |-> !$past(irq_enable_live) == 1'b0;
    endproperty
    a_int_gated: assert property (p_int_gated) else $error("int taken while disabled");
    property p_ei_sets;
        exec_irq_enable && !take_nmi && !take_int |=> irq_enable_live && irq_enable_saved;
    endproperty
    a_ei_sets: assert property (p_ei_sets) else $error("enable instr failed");
    // an nmi taken in the same cycle keeps the saved enable, so it is excluded
    property p_di_clears;
        exec_irq_mask && !exec_irq_enable && !take_nmi |=> !irq_enable_live && !irq_enable_saved;
    endproperty
    a_di_clears: assert property (p_di_clears) else $error("mask instr failed");
    property p_ei_holdoff;
        instr_boundary && (ei_hold || exec_irq_enable) |=> !int_accept;
    endproperty
    a_ei_holdoff: assert property (p_ei_holdoff) else $error("int too soon after enable");
    property p_int_clears;
        int_accept |-> !irq_enable_live && !irq_enable_saved;
    endproperty
    a_int_clears: assert property (p_int_clears) else $error("int accept kept enables");
    property p_nmi_keeps_saved;
        take_nmi |=> !irq_enable_live && $stable(irq_enable_saved);
    endproperty
    a_nmi_keeps_saved: assert property (p_nmi_keeps_saved) else $error("nmi touched saved");
    property p_parity_copy;
        exec_load_acc_vb || exec_load_acc_rf |=> parity_load && parity_value == $past(irq_enable_saved);
    endproperty
    a_parity_copy: assert property (p_parity_copy) else $error("parity copy wrong");
    property p_return_from_nonmaskable;
        exec_return_from_nonmaskable && !take_nmi && !take_int && !exec_irq_enable && !exec_irq_mask
        |=> irq_enable_live == $past(irq_enable_saved) && $stable(irq_enable_saved);
    endproperty
    a_return_from_nonmaskable: assert property (p_return_from_nonmaskable) else $error("return restore wrong");
    property p_boundary_only;
        nmi_accept || int_accept |-> $past(instr_boundary);
    endproperty
    a_boundary_only: assert property (p_boundary_only) else $error("accept off boundary");
    property p_mode1;
        int_accept && $past(int_mode) == cie_pkg::CIE_MODE1 |-> jump_valid && push_pc
        && jump_addr == cie_pkg::MODE1_VECTOR && wait_states == cie_pkg::INT_WAIT_STATES;
    endproperty
    a_mode1: assert property (p_mode1) else $error("mode 1 response wrong");
    property p_mode2;
        int_accept && $past(int_mode) == cie_pkg::CIE_MODE2 |-> table_valid && push_pc
        && table_ptr[15:8] == $past(vector_base) && !table_ptr[0];
    endproperty
    a_mode2: assert property (p_mode2) else $error("mode 2 pointer wrong");
    property p_nmi_latch;
        nmi_edge |=> nmi_pending;
    endproperty
    a_nmi_latch: assert property (p_nmi_latch) else $error("nmi edge lost");

endmodule : cie_unit

`default_nettype wire

// ---- cie_unit_tb_top.sv ----
// self-checking bench for the interrupt enable and response unit
// assumes the cie_periph model drives the request pins, bench plays core and apb
`timescale 1ns/1ps
`default_nettype none

module cie_unit_tb_top;
    localparam logic [5:0] EI = 6'h01;
    localparam logic [5:0] DI = 6'h02;
    localparam logic [5:0] VB = 6'h04;
    localparam logic [5:0] RF = 6'h08;
    localparam logic [5:0] RN = 6'h10;
    localparam logic [5:0] SM = 6'h20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [5:0] ex = 6'h00;
    logic instr_boundary = 1'b0;
    logic nmi_req = 1'b0;
    logic int_req = 1'b0;
    logic [1:0] exec_mode = 2'h2;
    logic [7:0] vector_base = 8'hA5;
    logic [7:0] vec_in = 8'h3B;
    logic [31:0] prdata;
    logic pready, pslverr, nmi_n, int_n, live, saved, parity_load, parity_value;
    logic nmi_accept, int_accept, discard_fetch, push_pc, jump_valid, table_valid, bus_instr;
    logic [7:0] periph_vector;
    logic [15:0] jump_addr, table_ptr;
    logic [1:0] wait_states, int_mode;
    logic [15:0] flags, stv;
    logic [31:0] d;
    logic e;
    int failures = 0;
    int check_count = 0;

    assign flags = {8'h00, nmi_accept, int_accept, discard_fetch, push_pc, jump_valid,
                    table_valid, bus_instr, parity_load};
    assign stv = {11'h000, int_mode, parity_value, live, saved};

    always #5 pclk = ~pclk;

    cie_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_n(nmi_n), .int_n(int_n), .instr_boundary(instr_boundary),
        .exec_irq_enable(ex[0]), .exec_irq_mask(ex[1]), .exec_load_acc_vb(ex[2]),
        .exec_load_acc_rf(ex[3]), .exec_return_from_nonmaskable(ex[4]), .exec_set_mode(ex[5]),
        .exec_mode(exec_mode), .vector_base(vector_base), .periph_vector(periph_vector),
        .irq_enable_live(live), .irq_enable_saved(saved), .parity_load(parity_load),
        .parity_value(parity_value), .nmi_accept(nmi_accept), .int_accept(int_accept),
        .discard_fetch(discard_fetch), .push_pc(push_pc), .jump_valid(jump_valid),
        .jump_addr(jump_addr), .table_valid(table_valid), .table_ptr(table_ptr),
        .bus_instr(bus_instr), .wait_states(wait_states), .int_mode(int_mode));

    cie_periph periph_u (.pclk(pclk), .presetn(presetn), .nmi_req(nmi_req),
        .int_req(int_req), .vec_in(vec_in), .int_accept(int_accept), .nmi_n(nmi_n),
        .int_n(int_n), .periph_vector(periph_vector));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // held until pready is sampled high; the bound is only a hang guard
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            conclude();
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    // one-cycle core pulse; its effects are visible after the next edge
    task automatic step(input logic [5:0] x);
        @(posedge pclk);
        ex <= x;
        @(posedge pclk);
        ex <= 6'h00;
        #1;
    endtask : step

    task automatic bnd;
        @(posedge pclk);
        instr_boundary <= 1'b1;
        @(posedge pclk);
        instr_boundary <= 1'b0;
        #1;
    endtask : bnd

    // request pulse, then time for the pin synchronisers
    task automatic req(input logic is_nmi);
        @(posedge pclk);
        nmi_req <= is_nmi;
        int_req <= ~is_nmi;
        @(posedge pclk);
        nmi_req <= 1'b0;
        int_req <= 1'b0;
        repeat (4) @(posedge pclk);
        #1;
    endtask : req

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, cie_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0);
        chk("status", 16'h0000, d[15:0]);
        apb(1'b0, cie_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", 16'h0000, d[15:0]);
        apb(1'b0, 12'h008, 32'h0);
        chk("slverr", 16'h0001, {15'h0000, e});
        $display("test reset done");
        req(1'b0);
        bnd;
        chk("flags", 16'h0000, flags);
        step(EI);
        chk("enables", 16'h0003, stv);
        apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0);
        chk("status", 16'h000B, d[15:0]);
        bnd;
        chk("flags", 16'h0000, flags);
        bnd;
        chk("flags", 16'h0042, flags);
        chk("waits", 16'h0002, {14'h0000, wait_states});
        chk("enables", 16'h0000, stv);
        $display("test mode 0 done");
        apb(1'b1, cie_pkg::ADDR_CTRL, 32'h0000_0001);
        chk("mode", 16'h0008, stv);
        step(EI);
        bnd;
        req(1'b0);
        bnd;
        chk("flags", 16'h0058, flags);
        chk("jump", 16'h0038, jump_addr);
        chk("waits", 16'h0002, {14'h0000, wait_states});
        chk("enables", 16'h0008, stv);
        $display("test mode 1 done");
        step(SM);
        chk("mode", 16'h0010, stv);
        step(EI);
        bnd;
        req(1'b0);
        bnd;
        chk("flags", 16'h0054, flags);
        chk("table", 16'hA53A, table_ptr);
        chk("enables", 16'h0010, stv);
        $display("test mode 2 done");
        step(EI);
        bnd;
        req(1'b1);
        apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0);
        chk("status", 16'h0027, d[15:0]);
        chk("flags", 16'h0000, flags);
        bnd;
        chk("flags", 16'h00B8, flags);
        chk("jump", 16'h0066, jump_addr);
        chk("waits", 16'h0000, {14'h0000, wait_states});
        chk("enables", 16'h0011, stv);
        step(VB);
        chk("flags", 16'h0001, flags);
        chk("enables", 16'h0015, stv);
        step(RF);
        chk("flags", 16'h0001, flags);
        chk("enables", 16'h0015, stv);
        step(RN);
        chk("enables", 16'h0017, stv);
        step(DI);
        chk("enables", 16'h0014, stv);
        step(VB);
        chk("enables", 16'h0010, stv);
        req(1'b1);
        bnd;
        chk("flags", 16'h00B8, flags);
        chk("enables", 16'h0010, stv);
        $display("test non-maskable done");
        conclude();
    end
endmodule : cie_unit_tb_top

`default_nettype wire
